//--- common/alu_pkg.sv
// constants shared by the subtract, test and trap execution unit
package alu_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFF_REG_BASE = 8'h00; // r0..r15 at 0x00..0x3c
   localparam logic [7:0] OFF_REG_LAST = 8'h3c;
   localparam logic [7:0] OFF_STATUS = 8'h40;
   localparam logic [7:0] OFF_INSTR = 8'h44;
   localparam logic [7:0] OFF_PC = 8'h48;
   localparam logic [7:0] OFF_RESULT = 8'h4c;
   localparam logic [7:0] OFF_EXEC_STAT = 8'h50;
   // ----------------------------------------
   // instruction fields
   // ----------------------------------------
   localparam int COND_HI = 31;
   localparam int COND_LO = 28;
   localparam int CLASS_HI = 27;
   localparam int CLASS_LO = 26;
   localparam int TRAP_HI = 27;
   localparam int TRAP_LO = 24;
   localparam int IMM_BIT = 25;
   localparam int OPC_HI = 24;
   localparam int OPC_LO = 21;
   localparam int SFLAG_BIT = 20;
   localparam int RN_HI = 19;
   localparam int RN_LO = 16;
   localparam int RD_HI = 15;
   localparam int RD_LO = 12;
   localparam int ROT_HI = 11;
   localparam int ROT_LO = 8;
   localparam int IMM8_HI = 7;
   localparam int SHAMT_HI = 11;
   localparam int SHAMT_LO = 7;
   localparam int STYPE_HI = 6;
   localparam int STYPE_LO = 5;
   localparam int REGSHIFT_BIT = 4;
   localparam int RS_HI = 11;
   localparam int RS_LO = 8;
   localparam int COMMENT_W = 24;
   localparam logic [1:0] CLASS_DP = 2'h0;
   localparam logic [3:0] CLASS_TRAP = 4'hf;
   localparam logic [3:0] OP_SUB = 4'h2;
   localparam logic [3:0] OP_TST = 4'h8;
   localparam logic [3:0] OP_TEQ = 4'h9;
   localparam logic [3:0] RD_DIRECT = 4'hf; // test with this rd = direct load
   // ----------------------------------------
   // shift types and condition codes
   // ----------------------------------------
   localparam logic [1:0] SH_LSL = 2'h0;
   localparam logic [1:0] SH_LSR = 2'h1;
   localparam logic [1:0] SH_ASR = 2'h2;
   localparam logic [1:0] SH_ROR = 2'h3;
   localparam logic [3:0] CC_EQ = 4'h0, CC_NE = 4'h1, CC_CS = 4'h2;
   localparam logic [3:0] CC_CC = 4'h3, CC_MI = 4'h4, CC_PL = 4'h5;
   localparam logic [3:0] CC_VS = 4'h6, CC_VC = 4'h7, CC_HI = 4'h8;
   localparam logic [3:0] CC_LS = 4'h9, CC_GE = 4'ha, CC_LT = 4'hb;
   localparam logic [3:0] CC_GT = 4'hc, CC_LE = 4'hd, CC_AL = 4'he;
   // ----------------------------------------
   // status word layout and constants
   // ----------------------------------------
   localparam int PSW_N = 31;
   localparam int PSW_Z = 30;
   localparam int PSW_C = 29;
   localparam int PSW_V = 28;
   localparam logic [31:0] PSW_MASK_EQ = 32'hf000_0003;
   localparam logic [31:0] PSW_MASK_TST = 32'hf000_0000;
   localparam logic [31:0] PSW_RESET = 32'h0000_0003; // supervisor
   localparam logic [1:0] MODE_SVC = 2'h3;
   localparam logic [31:0] TRAP_VECTOR = 32'h0000_0008;
   localparam logic [31:0] PC_STEP = 32'h0000_0004;
   localparam logic [31:0] PC_RESET = 32'h0000_0000;
   typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage

//--- src/operand_shifter.sv
// barrel shifter that forms the second operand and its carry out
`timescale 1ns/10ps
module operand_shifter
   import alu_pkg::*;
#(
   parameter int DATA_W = 32
) (
   // operand and shift control
   input wire logic [DATA_W-1:0] value_in,
   input wire logic [1:0] type_in,
   input wire logic [7:0] amount_in,
   input wire logic by_reg_in,
   input wire logic carry_in,
   // shifted operand
   output logic [DATA_W-1:0] result_out,
   output logic carry_out
);
   logic [DATA_W:0] wide;
   logic [2*DATA_W-1:0] twice;
   logic [7:0] n;

   // -----------------------------------------
   // shift by immediate or register count
   // -----------------------------------------
   always_comb begin
      wide = '0;
      twice = '0;
      n = amount_in;
      result_out = value_in;
      carry_out = carry_in;
      // encoded zero means 32 for right shifts, one-bit rrx for ror
      if (!by_reg_in && n == 8'h00 && (type_in == SH_LSR || type_in == SH_ASR))
         n = 8'h20;
      if (n > 8'h20)
         n = (type_in == SH_ROR) ? n : 8'h21;
      if (!by_reg_in && n == 8'h00 && type_in == SH_ROR) begin
         result_out = {carry_in, value_in[DATA_W-1:1]};
         carry_out = value_in[0];
      end else if (n != 8'h00) begin
         case (type_in)
            SH_LSL: begin
               wide = {1'b0, value_in} << n;
               result_out = wide[DATA_W-1:0];
               carry_out = wide[DATA_W];
            end
            SH_LSR: begin
               wide = {value_in, 1'b0} >> n;
               result_out = wide[DATA_W:1];
               carry_out = wide[0];
            end
            SH_ASR: begin
               wide = $signed({value_in, 1'b0}) >>> ((n > 8'h20) ? 8'h20 : n);
               result_out = wide[DATA_W:1];
               carry_out = wide[0];
            end
            default: begin
               twice = {value_in, value_in} >> n[4:0];
               result_out = twice[DATA_W-1:0];
               carry_out = twice[DATA_W-1];
            end
         endcase
      end
   end
endmodule

//--- src/cond_check.sv
// condition field evaluation against the current flags
`timescale 1ns/10ps
module cond_check
   import alu_pkg::*;
(
   // condition and flags
   input wire logic [3:0] cond_in,
   input wire logic [3:0] nzcv_in,
   // verdict
   output logic pass_out
);
   logic n, z, c, v;

   // ----------------------------------------
   // decode the 4-bit condition field
   // ----------------------------------------
   always_comb begin
      {n, z, c, v} = nzcv_in;
      case (cond_in)
         CC_EQ: pass_out = z;
         CC_NE: pass_out = !z;
         CC_CS: pass_out = c;
         CC_CC: pass_out = !c;
         CC_MI: pass_out = n;
         CC_PL: pass_out = !n;
         CC_VS: pass_out = v;
         CC_VC: pass_out = !v;
         CC_HI: pass_out = c && !z;
         CC_LS: pass_out = !c || z;
         CC_GE: pass_out = (n == v);
         CC_LT: pass_out = (n != v);
         CC_GT: pass_out = !z && (n == v);
         CC_LE: pass_out = z || (n != v);
         CC_AL: pass_out = 1'b1;
         default: pass_out = 1'b0; // never-execute code
      endcase
   end
endmodule

//--- src/alu_subtract_test_trap_ops.sv
// execution unit for subtract, equivalence test, bit test and trap
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps

// What this block does
// - subtract writes first register minus second operand into destination.
// - subtract updates n, z, c, v only when the set-flags bit is set.
// - immediate operand is an 8-bit value rotated right by twice rot.
// - register-count shifts support counts 1 through 32 and beyond.
// - constant shifts 1..31 with lsl, lsr, asr, ror plus one-bit rrx.
// - trap enters supervisor mode and jumps to vector address 0x8.
// - trap's low 24-bit comment field is ignored by hardware.
// - the 4-bit condition field is checked against current flags.
// - equivalence test xors operands and writes no register.
// - equivalence test clears carry and keeps overflow.
// - bit test ands operands, updates n, z, c, writes no register.
// - bit test keeps the overflow flag unchanged.
// - both tests always update flags, set-flags bit or not.
// - direct-load equivalence test copies result bits 31:28 and 1:0.
// - direct-load bit test copies result bits 31:28 only.
// - a failed condition leaves registers and flags untouched.
module alu_subtract_test_trap_ops
   import alu_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int NUM_REGS = 16
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // avalon-mm slave
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [DATA_W-1:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // core status
   output logic [1:0] mode_out,
   output logic trap_out
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   bus_state_t bus_state_q;
   logic [DATA_W-1:0] reg_file_q [NUM_REGS];
   logic [DATA_W-1:0] psw_q;
   logic [DATA_W-1:0] pc_q;
   logic [DATA_W-1:0] result_q;
   logic [2:0] exec_stat_q;
   logic [DATA_W-1:0] instr_q;
   logic [DATA_W-1:0] readdata_q;
   logic trap_q;

   // decode and datapath nets
   logic bus_req;
   logic bus_take;
   logic wr_take;
   logic exec_go;
   logic [DATA_W-1:0] instr;
   logic cond_pass;
   logic is_dp;
   logic is_trap;
   logic is_sub;
   logic is_tst;
   logic is_teq;
   logic known_op;
   logic direct_load;
   logic [3:0] opcode;
   logic [3:0] rn_idx;
   logic [3:0] rd_idx;
   logic [DATA_W-1:0] op_a;
   logic [DATA_W-1:0] sh_value;
   logic [1:0] sh_type;
   logic [7:0] sh_amount;
   logic sh_by_reg;
   logic [DATA_W-1:0] op_b;
   logic sh_carry;
   logic [DATA_W:0] diff_wide;
   logic [DATA_W-1:0] alu_res;
   logic sub_carry;
   logic sub_ovf;
   logic [DATA_W-1:0] psw_d;
   logic do_exec;

   // merge write data into a word under byte enables
   function automatic logic [DATA_W-1:0] merge_bytes(
      input logic [DATA_W-1:0] old_val,
      input logic [DATA_W-1:0] new_val,
      input logic [3:0] be
   );
      logic [DATA_W-1:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (be[i])
            res[i*8 +: 8] = new_val[i*8 +: 8];
      end
      return res;
   endfunction

   // ----------------------------------------
   // avalon handshake
   // ----------------------------------------
   // each access waits one cycle, then completes in the answer cycle
   assign bus_req = avs_read_in || avs_write_in;
   assign avs_waitrequest_out = bus_req && (bus_state_q != BUS_ANSWER);
   assign bus_take = bus_req && (bus_state_q == BUS_ANSWER);
   assign wr_take = bus_take && avs_write_in;
   assign exec_go = wr_take && (avs_address_in == OFF_INSTR);

   // bus sequencer
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bus_state_q <= BUS_IDLE;
      end else begin
         case (bus_state_q)
            BUS_IDLE: begin
               if (bus_req)
                  bus_state_q <= BUS_ANSWER;
            end
            BUS_ANSWER: bus_state_q <= BUS_IDLE;
            default: bus_state_q <= BUS_IDLE;
         endcase
      end
   end

   // read data captured in the wait cycle, held through the answer
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         readdata_q <= '0;
      end else if (avs_read_in && bus_state_q == BUS_IDLE) begin
         if (avs_address_in <= OFF_REG_LAST && avs_address_in[1:0] == 2'h0)
            readdata_q <= reg_file_q[avs_address_in[5:2]];
         else begin
            case (avs_address_in)
               OFF_STATUS: readdata_q <= psw_q;
               OFF_INSTR: readdata_q <= instr_q;
               OFF_PC: readdata_q <= pc_q;
               OFF_RESULT: readdata_q <= result_q;
               OFF_EXEC_STAT: readdata_q <= {29'h0000_0000, exec_stat_q};
               default: readdata_q <= '0; // unmapped reads zero
            endcase
         end
      end
   end
   assign avs_readdata_out = readdata_q;

   // ----------------------------------------
   // instruction decode
   // ----------------------------------------
   assign instr = avs_writedata_in;
   assign opcode = instr[OPC_HI:OPC_LO];
   assign rn_idx = instr[RN_HI:RN_LO];
   assign rd_idx = instr[RD_HI:RD_LO];
   assign is_trap = (instr[TRAP_HI:TRAP_LO] == CLASS_TRAP);
   assign is_dp = (instr[CLASS_HI:CLASS_LO] == CLASS_DP);
   assign is_sub = is_dp && (opcode == OP_SUB);
   assign is_tst = is_dp && (opcode == OP_TST);
   assign is_teq = is_dp && (opcode == OP_TEQ);
   assign known_op = is_trap || is_sub || is_tst || is_teq;
   assign direct_load = (rd_idx == RD_DIRECT);
   assign op_a = reg_file_q[rn_idx];

   // condition gate on the current flags
   cond_check u_cond (
      .cond_in (instr[COND_HI:COND_LO]),
      .nzcv_in (psw_q[PSW_N:PSW_V]),
      .pass_out (cond_pass)
   );
   assign do_exec = exec_go && cond_pass && known_op;

   // ----------------------------------------
   // second operand formation
   // ----------------------------------------
   always_comb begin
      if (instr[IMM_BIT]) begin
         // rotate by twice the 4-bit field, carry kept when unrotated
         sh_value = {24'h00_0000, instr[IMM8_HI:0]};
         sh_type = SH_ROR;
         sh_amount = {3'h0, instr[ROT_HI:ROT_LO], 1'b0};
         sh_by_reg = 1'b1;
      end else begin
         sh_value = reg_file_q[instr[3:0]];
         sh_type = instr[STYPE_HI:STYPE_LO];
         sh_by_reg = instr[REGSHIFT_BIT];
         if (instr[REGSHIFT_BIT])
            sh_amount = reg_file_q[instr[RS_HI:RS_LO]][7:0];
         else
            sh_amount = {3'h0, instr[SHAMT_HI:SHAMT_LO]};
      end
   end

   operand_shifter #(
      .DATA_W (DATA_W)
   ) u_shift (
      .value_in (sh_value),
      .type_in (sh_type),
      .amount_in (sh_amount),
      .by_reg_in (sh_by_reg),
      .carry_in (psw_q[PSW_C]),
      .result_out (op_b),
      .carry_out (sh_carry)
   );

   // ----------------------------------------
   // arithmetic and logic
   // ----------------------------------------
   // subtract as a plus not b plus one; carry out is not-borrow
   assign diff_wide = {1'b0, op_a} + {1'b0, ~op_b} + 33'h0_0000_0001;
   assign sub_carry = diff_wide[DATA_W];
   assign sub_ovf = (op_a[DATA_W-1] != op_b[DATA_W-1]) &&
                    (diff_wide[DATA_W-1] != op_a[DATA_W-1]);

   // result select
   always_comb begin
      if (is_teq)
         alu_res = op_a ^ op_b;
      else if (is_tst)
         alu_res = op_a & op_b;
      else
         alu_res = diff_wide[DATA_W-1:0];
   end

   // next status word
   always_comb begin
      psw_d = psw_q;
      if (is_trap) begin
         psw_d[1:0] = MODE_SVC;
      end else if (is_sub) begin
         if (instr[SFLAG_BIT]) begin
            psw_d[PSW_N] = alu_res[DATA_W-1];
            psw_d[PSW_Z] = (alu_res == '0);
            psw_d[PSW_C] = sub_carry;
            psw_d[PSW_V] = sub_ovf;
         end
      end else if (is_teq && direct_load) begin
         psw_d = (psw_q & ~PSW_MASK_EQ) | (alu_res & PSW_MASK_EQ);
      end else if (is_tst && direct_load) begin
         psw_d = (psw_q & ~PSW_MASK_TST) | (alu_res & PSW_MASK_TST);
      end else if (is_teq || is_tst) begin
         // flags taken regardless of the set-flags bit
         psw_d[PSW_N] = alu_res[DATA_W-1];
         psw_d[PSW_Z] = (alu_res == '0);
         psw_d[PSW_C] = is_tst ? sh_carry : 1'b0;
         // overflow left as it was
         psw_d[PSW_V] = psw_q[PSW_V];
      end
   end

   // ----------------------------------------
   // status word
   // ----------------------------------------
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         psw_q <= PSW_RESET;
      end else if (do_exec) begin
         psw_q <= psw_d;
      end else if (wr_take && avs_address_in == OFF_STATUS) begin
         psw_q <= merge_bytes(psw_q, avs_writedata_in, avs_byteenable_in) &
                  PSW_MASK_EQ;
      end
   end
   assign mode_out = psw_q[1:0];

   // ----------------------------------------
   // register file
   // ----------------------------------------
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < NUM_REGS; i++)
            reg_file_q[i] <= '0;
      end else if (do_exec && is_sub) begin
         reg_file_q[rd_idx] <= alu_res;
      end else if (wr_take && avs_address_in <= OFF_REG_LAST &&
                   avs_address_in[1:0] == 2'h0) begin
         reg_file_q[avs_address_in[5:2]] <=
            merge_bytes(reg_file_q[avs_address_in[5:2]], avs_writedata_in,
                        avs_byteenable_in);
      end
   end

   // ----------------------------------------
   // program counter
   // ----------------------------------------
   // the trap comment field is never looked at here
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pc_q <= PC_RESET;
      end else if (do_exec && is_trap) begin
         pc_q <= TRAP_VECTOR;
      end else if (exec_go) begin
         pc_q <= pc_q + PC_STEP;
      end else if (wr_take && avs_address_in == OFF_PC) begin
         pc_q <= merge_bytes(pc_q, avs_writedata_in, avs_byteenable_in);
      end
   end

   // ----------------------------------------
   // trace of the last instruction
   // ----------------------------------------
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         instr_q <= '0;
         result_q <= '0;
         exec_stat_q <= 3'h0;
      end else if (exec_go) begin
         instr_q <= instr;
         // unsupported, trap taken, skipped
         exec_stat_q <= {!known_op, do_exec && is_trap, !cond_pass};
         if (do_exec && !is_trap)
            result_q <= alu_res; // discarded test results stay visible
      end
   end

   // one-cycle pulse on trap entry
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in)
         trap_q <= 1'b0;
      else
         trap_q <= do_exec && is_trap;
   end
   assign trap_out = trap_q;
endmodule

//--- verif/alu_checker_properties.sv
// concurrent checks on the execution unit's bus handshake and status pins
`timescale 1ns/10ps
module alu_checker
   import alu_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int NUM_REGS = 16
) (
   // watched ports
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [DATA_W-1:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [DATA_W-1:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic [1:0] mode_out,
   input wire logic trap_out
);
   // ----------------------------------------
   // helper terms
   // ----------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   logic req;
   logic taken;
   logic trap_w;
   // request, taking edge and trap word taken at the instruction address, condition not checked
   assign req = avs_read_in | avs_write_in;
   assign taken = avs_write_in & ~avs_waitrequest_out;
   assign trap_w = taken && avs_address_in == OFF_INSTR &&
      avs_writedata_in[TRAP_HI:TRAP_LO] == CLASS_TRAP;
   sequence instr_taken;
      taken && avs_address_in == OFF_INSTR;
   endsequence
   sequence never_trap;
      avs_writedata_in[TRAP_HI:TRAP_LO] == CLASS_TRAP &&
      avs_writedata_in[COND_HI:COND_LO] == 4'hf;
   endsequence
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   chk_wait_answer: assert property (req && avs_waitrequest_out
      |=> !avs_waitrequest_out) else $error("answer late");
   chk_wait_idle: assert property (!req |-> !avs_waitrequest_out)
      else $error("waitrequest without request");
   chk_one_answer: assert property (req && !avs_waitrequest_out
      |=> !(req && !avs_waitrequest_out)) else $error("double answer");
   chk_read_stands: assert property (!avs_read_in
      |=> $stable(avs_readdata_out)) else $error("read data moved");
   chk_trap_pulse: assert property (trap_out |=> !trap_out)
      else $error("trap pulse too long");
   chk_trap_mode: assert property (trap_out |-> mode_out == MODE_SVC)
      else $error("trap without supervisor mode");
   chk_trap_cause: assert property ($rose(trap_out)
      |-> $past(trap_w) || $past(trap_w, 2)) else $error("stray trap");
   chk_mode_cause: assert property ($changed(mode_out)
      |-> $past(taken && (avs_address_in == OFF_STATUS ||
      avs_address_in == OFF_INSTR))) else $error("mode moved alone");
   chk_tst_mode: assert property (instr_taken ##0
      (avs_writedata_in[OPC_HI:OPC_LO] != OP_TEQ &&
      avs_writedata_in[TRAP_HI:TRAP_LO] != CLASS_TRAP)
      |=> $stable(mode_out)) else $error("mode changed");
   chk_never_trap: assert property (instr_taken ##0 never_trap
      |=> !trap_out [*2]) else $error("never code trapped");
endmodule

bind alu_subtract_test_trap_ops alu_checker #(
   .DATA_W(DATA_W),
   .NUM_REGS(NUM_REGS)
) u_checker (
   .core_clk_in(core_clk_in),
   .rstn_in(rstn_in),
   .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in),
   .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out),
   .mode_out(mode_out),
   .trap_out(trap_out)
);

//--- verif/tb_top.sv
// self-checking bench for the subtract, test and trap execution unit
`timescale 1ns/10ps
module tb_top
   import alu_pkg::*;
;
   logic clk, rstn, rd, wr, wreq, trap;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, q;
   logic [3:0] be;
   logic [1:0] mode;
   int miscompares, tests_run, trap_cnt;

   alu_subtract_test_trap_ops u_dut (
      .core_clk_in(clk),
      .rstn_in(rstn),
      .avs_address_in(addr),
      .avs_read_in(rd),
      .avs_write_in(wr),
      .avs_writedata_in(wdata),
      .avs_byteenable_in(be),
      .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq),
      .mode_out(mode),
      .trap_out(trap)
   );
   // ----------------------------------------
   // clock, trap counter and helpers
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // counts trap pulses seen at the pin
   always @(posedge clk) begin
      if (trap === 1'b1) trap_cnt <= trap_cnt + 1;
   end
   function automatic logic [7:0] ra(input logic [3:0] n);
      return {2'b00, n, 2'b00};
   endfunction
   function automatic logic [31:0] dp(input logic [3:0] c, op, rn, rdn,
      input logic i, s, input logic [11:0] o2);
      return {c, 2'b00, i, op, s, rn, rdn, o2};
   endfunction
   task automatic give_verdict;
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one avalon transfer, held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      logic done;
      int n;
      done = 1'b0;
      n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      while (!done && n < 20) begin
         @(posedge clk);
         done = (wreq === 1'b0);
         q = rdata;
         n++;
      end
      wr <= 1'b0;
      rd <= 1'b0;
      if (!done) begin
         miscompares++;
         give_verdict();
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rchk(input string what, input logic [7:0] a,
      input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(what, exp, q);
   endtask
   task automatic reset_dut;
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      rchk("status", OFF_STATUS, PSW_RESET);
      rchk("r3", ra(4'd3), 32'h0000_0000);
      rchk("pc", OFF_PC, PC_RESET);
      check("mode", 32'h0000_0003, {30'h0, mode});
   endtask
   task automatic t_sub;
      wreg(OFF_STATUS, 32'h0000_0003);
      wreg(ra(4'd1), 32'h0000_0005);
      wreg(ra(4'd2), 32'h0000_0007);
      wreg(OFF_INSTR, dp(CC_AL, OP_SUB, 4'd1, 4'd3, 1'b0, 1'b1, 12'h002));
      rchk("sub", ra(4'd3), 32'hffff_fffe);
      rchk("flags", OFF_STATUS, 32'h8000_0003);
      wreg(ra(4'd1), 32'h8000_0000);
      wreg(OFF_INSTR, dp(CC_AL, OP_SUB, 4'd1, 4'd3, 1'b1, 1'b0, 12'h001));
      rchk("sub", ra(4'd3), 32'h7fff_ffff);
      rchk("flags", OFF_STATUS, 32'h8000_0003);
      wreg(OFF_INSTR, dp(CC_AL, OP_SUB, 4'd1, 4'd3, 1'b1, 1'b1, 12'h001));
      rchk("flags", OFF_STATUS, 32'h3000_0003);
      wreg(OFF_INSTR, dp(CC_AL, OP_SUB, 4'd0, 4'd4, 1'b1, 1'b0, 12'h13f));
      rchk("imm", ra(4'd4), 32'h3fff_fff1);
   endtask
   task automatic t_shift;
      logic [11:0] op [10] = '{12'h205, 12'h225, 12'h245, 12'h265,
         12'hfa5, 12'h065, 12'h715, 12'h735, 12'h755, 12'h735};
      logic [31:0] rs [10] = '{0, 0, 0, 0, 0, 0, 32, 32, 32, 1};
      logic [31:0] ex [10] = '{32'h0000_0100, 32'h0800_0001,
         32'hf800_0001, 32'h0800_0001, 32'h0000_0001, 32'hc000_0008,
         32'h0000_0000, 32'h0000_0000, 32'hffff_ffff, 32'h4000_0008};
      wreg(OFF_STATUS, 32'h2000_0003);
      wreg(ra(4'd5), 32'h8000_0010);
      for (int k = 0; k < 10; k++) begin
         wreg(ra(4'd7), rs[k]);
         wreg(OFF_INSTR, dp(CC_AL, OP_SUB, 4'd0, 4'd6, 1'b0, 1'b0, op[k]));
         rchk("shift", ra(4'd6), 32'h0000_0000 - ex[k]);
      end
   endtask
   task automatic t_tests;
      wreg(OFF_STATUS, 32'h3000_0003);
      wreg(ra(4'd1), 32'h0000_0005);
      wreg(ra(4'd3), 32'h1234_5678);
      wreg(OFF_INSTR, dp(CC_AL, OP_TEQ, 4'd1, 4'd3, 1'b1, 1'b0, 12'h005));
      rchk("teq", OFF_STATUS, 32'h5000_0003);
      rchk("rd", ra(4'd3), 32'h1234_5678);
      wreg(OFF_STATUS, 32'h1000_0003);
      wreg(ra(4'd1), 32'h8000_0000);
      wreg(ra(4'd8), 32'hc000_0000);
      wreg(OFF_INSTR, dp(CC_AL, OP_TST, 4'd1, 4'd3, 1'b0, 1'b0, 12'h088));
      rchk("tst", OFF_STATUS, 32'hb000_0003);
      wreg(OFF_INSTR, dp(CC_AL, OP_TST, 4'd1, 4'd3, 1'b1, 1'b0, 12'h000));
      rchk("tst", OFF_STATUS, 32'h7000_0003);
      rchk("rd", ra(4'd3), 32'h1234_5678);
      wreg(ra(4'd9), 32'h0000_0001);
      wreg(OFF_INSTR, dp(CC_AL, OP_TEQ, 4'd9, RD_DIRECT, 1'b1, 1'b0,
         12'h1c3));
      rchk("teq load", OFF_STATUS, 32'hc000_0001);
      check("mode", 32'h0000_0001, {30'h0, mode});
      wreg(ra(4'd10), 32'hffff_ffff);
      wreg(OFF_INSTR, dp(CC_AL, OP_TST, 4'd10, RD_DIRECT, 1'b1, 1'b0,
         12'h253));
      rchk("tst load", OFF_STATUS, 32'h3000_0001);
   endtask
   task automatic t_trap;
      int tc;
      tc = trap_cnt;
      wreg(OFF_INSTR, {CC_AL, CLASS_TRAP, 24'hab_cdef});
      rchk("pc", OFF_PC, TRAP_VECTOR);
      rchk("status", OFF_STATUS, 32'h3000_0003);
      check("pulses", 32'(tc + 1), 32'(trap_cnt));
      wreg(OFF_STATUS, 32'h3000_0000);
      wreg(OFF_INSTR, {CC_EQ, CLASS_TRAP, 24'h00_0000});
      rchk("pc", OFF_PC, 32'h0000_000c);
      rchk("status", OFF_STATUS, 32'h3000_0000);
      rchk("fail", OFF_EXEC_STAT, 32'h0000_0001);
      wreg(OFF_INSTR, {4'hf, CLASS_TRAP, 24'h00_0000});
      check("pulses", 32'(tc + 1), 32'(trap_cnt));
   endtask
   task automatic t_cond;
      logic [15:0] pass_mask;
      pass_mask = 16'h66a5;
      wreg(OFF_STATUS, 32'h6000_0003);
      for (int c = 0; c < 16; c++) begin
         wreg(ra(4'd11), 32'h0000_0000);
         wreg(OFF_INSTR, dp(4'(c), OP_SUB, 4'd0, 4'd11, 1'b1, 1'b0,
            12'h001));
         rchk("cond", ra(4'd11), {32{pass_mask[c]}});
      end
      rchk("status", OFF_STATUS, 32'h6000_0003);
   endtask
   task automatic t_bus;
      wreg(8'h7c, 32'hffff_ffff);
      rchk("unmapped", 8'h7c, 32'h0000_0000);
      rchk("misaligned", 8'h01, 32'h0000_0000);
      wreg(OFF_INSTR, dp(CC_AL, 4'h0, 4'd0, 4'd0, 1'b1, 1'b0, 12'h000));
      rchk("unsupported", OFF_EXEC_STAT, 32'h0000_0004);
      wreg(OFF_STATUS, 32'hffff_ffff);
      rchk("status", OFF_STATUS, 32'hf000_0003);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      be = 4'hf;
      reset_dut();
      t_reset();
      t_sub();
      t_shift();
      t_tests();
      t_trap();
      t_cond();
      t_bus();
      reset_dut();
      t_reset();
      give_verdict();
   end
endmodule
